// ### logic/status_out_sel.sv
/*
 * Status-output selector of a motor drive: derives run and frequency
 * arrival flags from the generated frequency and routes any of them to two
 * normally-open relays and one changeover alarm relay.
 * Assumes the frequency generator and fault logic sit on pclk, so their
 * inputs need no synchroniser; software sets the map over APB.
 */
module status_out_sel (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Drive state
   input wire logic [status_out_pkg::FREQ_W-1:0] out_freq,
   input wire logic alarm_in,
   // Relay contacts
   output status_out_pkg::relay_t relays
);
   localparam int W = status_out_pkg::FREQ_W;

   // Window membership within a band around a threshold
   function automatic logic near_thr(input logic [W-1:0] f,
         input logic [W-1:0] thr, input logic [W-1:0] band);
      logic [W:0] lo;
      logic [W:0] hi;
      lo = ({1'b0, thr} > {1'b0, band}) ? {1'b0, thr} - {1'b0, band}
         : '0;
      hi = {1'b0, thr} + {1'b0, band};
      near_thr = ({1'b0, f} >= lo) && ({1'b0, f} <= hi);
   endfunction

   // Option code to function level
   function automatic logic pick(input logic [7:0] code,
         input logic [4:0] fn);
      case (code)
         status_out_pkg::FN_RUN: pick = fn[0];
         status_out_pkg::FN_SETPOINT: pick = fn[1];
         status_out_pkg::FN_OVER_THR: pick = fn[2];
         status_out_pkg::FN_AT_THR: pick = fn[3];
         status_out_pkg::FN_ALARM: pick = fn[4];
         default: pick = 1'b0;
      endcase
   endfunction

   typedef enum logic [1:0] {DIR_ACCEL, DIR_DECEL} dir_t;

   // Configuration registers
   logic [7:0] sel1_q, sel1_d, sel2_q, sel2_d, sela_q, sela_d;
   logic [W-1:0] setf_q, setf_d, acc_q, acc_d, dec_q, dec_d;
   logic [W-1:0] startf_q, startf_d, maxf_q, maxf_d;
   // Flag state
   logic [W-1:0] prev_q, prev_d;
   dir_t dir_q, dir_d;
   logic run_q, run_d;
   logic arrival_at_setpoint_flag_q, arrival_at_setpoint_flag_d;
   logic arrival_over_threshold_flag_q, arrival_over_threshold_flag_d;
   logic arrival_at_threshold_pulse_q, arrival_at_threshold_pulse_d;
   status_out_pkg::relay_t rel_q, rel_d;
   logic [W-1:0] band_on, band_off;
   logic [W+7:0] prod_on, prod_off;
   logic wr_en, rd_en;
   logic [4:0] fn_vec;

   // Hysteresis bands from maximum frequency
   always_comb begin
      prod_on = {8'h00, maxf_q} * (W+8)'(status_out_pkg::ON_PCT);
      prod_off = {8'h00, maxf_q} * (W+8)'(status_out_pkg::OFF_PCT);
      band_on = W'(prod_on / (W+8)'(100));
      band_off = W'(prod_off / (W+8)'(100));
   end

   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && !pwrite;
   assign pready = 1'b1;

   // Register write decode
   always_comb begin
      sel1_d = sel1_q;
      sel2_d = sel2_q;
      sela_d = sela_q;
      setf_d = setf_q;
      acc_d = acc_q;
      dec_d = dec_q;
      startf_d = startf_q;
      maxf_d = maxf_q;
      if (wr_en) begin
         case (paddr)
            status_out_pkg::OFS_SEL_OUT1: sel1_d = pwdata[7:0];
            status_out_pkg::OFS_SEL_OUT2: sel2_d = pwdata[7:0];
            status_out_pkg::OFS_SEL_ALARM: sela_d = pwdata[7:0];
            status_out_pkg::OFS_SET_FREQ: setf_d = pwdata[W-1:0];
            status_out_pkg::OFS_ACC_THR: acc_d = pwdata[W-1:0];
            status_out_pkg::OFS_DEC_THR: dec_d = pwdata[W-1:0];
            status_out_pkg::OFS_START_FREQ: startf_d = pwdata[W-1:0];
            status_out_pkg::OFS_MAX_FREQ: maxf_d = pwdata[W-1:0];
            default: ;
         endcase
      end
   end

   // Unmapped addresses, and writes to the status register, answer with an error
   always_comb begin
      case (paddr)
         status_out_pkg::OFS_SEL_OUT1, status_out_pkg::OFS_SEL_OUT2,
         status_out_pkg::OFS_SEL_ALARM, status_out_pkg::OFS_SET_FREQ,
         status_out_pkg::OFS_ACC_THR, status_out_pkg::OFS_DEC_THR,
         status_out_pkg::OFS_START_FREQ, status_out_pkg::OFS_MAX_FREQ:
            pslverr = 1'b0;
         status_out_pkg::OFS_STATUS: pslverr = psel && penable && pwrite;
         default: pslverr = psel && penable;
      endcase
   end

   // Read data, registered during the setup cycle
   logic [31:0] rdata_q, rdata_d;
   always_comb begin
      rdata_d = rdata_q;
      if (rd_en && !penable) begin
         rdata_d = 32'h0000_0000;
         case (paddr)
            status_out_pkg::OFS_SEL_OUT1: rdata_d[7:0] = sel1_q;
            status_out_pkg::OFS_SEL_OUT2: rdata_d[7:0] = sel2_q;
            status_out_pkg::OFS_SEL_ALARM: rdata_d[7:0] = sela_q;
            status_out_pkg::OFS_SET_FREQ: rdata_d[W-1:0] = setf_q;
            status_out_pkg::OFS_ACC_THR: rdata_d[W-1:0] = acc_q;
            status_out_pkg::OFS_DEC_THR: rdata_d[W-1:0] = dec_q;
            status_out_pkg::OFS_START_FREQ: rdata_d[W-1:0] = startf_q;
            status_out_pkg::OFS_MAX_FREQ: rdata_d[W-1:0] = maxf_q;
            status_out_pkg::OFS_STATUS: begin
               rdata_d[status_out_pkg::ST_RUN] = run_q;
               rdata_d[status_out_pkg::ST_SETPOINT] =
                  arrival_at_setpoint_flag_q;
               rdata_d[status_out_pkg::ST_OVER] =
                  arrival_over_threshold_flag_q;
               rdata_d[status_out_pkg::ST_AT] =
                  arrival_at_threshold_pulse_q;
               rdata_d[status_out_pkg::ST_ACCEL] = (dir_q == DIR_ACCEL);
               rdata_d[status_out_pkg::ST_DECEL] = (dir_q == DIR_DECEL);
            end
            default: ;
         endcase
      end
   end
   assign prdata = rdata_q;

   // Direction and arrival flags
   always_comb begin
      prev_d = out_freq;
      dir_d = dir_q;
      if (out_freq > prev_q) begin
         dir_d = DIR_ACCEL;
      end else if (out_freq < prev_q) begin
         dir_d = DIR_DECEL;
      end
      run_d = (out_freq > startf_q);
      // Set frequency: early on, late off
      if (near_thr(out_freq, setf_q, band_on)) begin
         arrival_at_setpoint_flag_d = 1'b1;
      end else if (!near_thr(out_freq, setf_q, band_off)) begin
         arrival_at_setpoint_flag_d = 1'b0;
      end else begin
         arrival_at_setpoint_flag_d = arrival_at_setpoint_flag_q;
      end
      // Over-threshold: on at accel threshold, off under decel threshold
      arrival_over_threshold_flag_d = arrival_over_threshold_flag_q;
      if (dir_d == DIR_ACCEL && {1'b0, out_freq} + {1'b0, band_on}
            >= {1'b0, acc_q}) begin
         arrival_over_threshold_flag_d = 1'b1;
      end else if (dir_d == DIR_DECEL && {1'b0, out_freq}
            + {1'b0, band_off} < {1'b0, dec_q}) begin
         arrival_over_threshold_flag_d = 1'b0;
      end
      // At threshold pulses on each direction
      arrival_at_threshold_pulse_d = arrival_at_threshold_pulse_q;
      if ((dir_d == DIR_ACCEL && near_thr(out_freq, acc_q, band_on)) ||
            (dir_d == DIR_DECEL && near_thr(out_freq, dec_q, band_on))) begin
         arrival_at_threshold_pulse_d = 1'b1;
      end else if (!(dir_d == DIR_ACCEL &&
            near_thr(out_freq, acc_q, band_off)) && !(dir_d == DIR_DECEL
            && near_thr(out_freq, dec_q, band_off))) begin
         arrival_at_threshold_pulse_d = 1'b0;
      end
   end

   // Routing of functions to the contacts
   always_comb begin
      fn_vec = {alarm_in, arrival_at_threshold_pulse_d,
         arrival_over_threshold_flag_d, arrival_at_setpoint_flag_d, run_d};
      rel_d.out1_no = pick(sel1_q, fn_vec);
      rel_d.out2_no = pick(sel2_q, fn_vec);
      rel_d.alarm_no = pick(sela_q, fn_vec);
      rel_d.alarm_nc = !rel_d.alarm_no;
   end
   assign relays = rel_q;

   // State registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel1_q <= status_out_pkg::RST_SEL_OUT1;
         sel2_q <= status_out_pkg::RST_SEL_OUT2;
         sela_q <= status_out_pkg::RST_SEL_ALARM;
         setf_q <= status_out_pkg::RST_SET_FREQ;
         acc_q <= status_out_pkg::RST_ACC_THR;
         dec_q <= status_out_pkg::RST_DEC_THR;
         startf_q <= status_out_pkg::RST_START_FREQ;
         maxf_q <= status_out_pkg::RST_MAX_FREQ;
         rdata_q <= 32'h0000_0000;
         prev_q <= '0;
         dir_q <= DIR_ACCEL;
         run_q <= 1'b0;
         arrival_at_setpoint_flag_q <= 1'b0;
         arrival_over_threshold_flag_q <= 1'b0;
         arrival_at_threshold_pulse_q <= 1'b0;
         rel_q <= 4'h1;
      end else begin
         sel1_q <= sel1_d;
         sel2_q <= sel2_d;
         sela_q <= sela_d;
         setf_q <= setf_d;
         acc_q <= acc_d;
         dec_q <= dec_d;
         startf_q <= startf_d;
         maxf_q <= maxf_d;
         rdata_q <= rdata_d;
         prev_q <= prev_d;
         dir_q <= dir_d;
         run_q <= run_d;
         arrival_at_setpoint_flag_q <= arrival_at_setpoint_flag_d;
         arrival_over_threshold_flag_q <= arrival_over_threshold_flag_d;
         arrival_at_threshold_pulse_q <= arrival_at_threshold_pulse_d;
         rel_q <= rel_d;
      end
   end

   // Checks on the contacts and flags
   AST_ALARM_COMPL: assert property (
      @(posedge pclk) disable iff (!presetn)
      relays.alarm_nc == !relays.alarm_no)
      else $error("alarm contacts not complementary");
   AST_RUN_FOLLOWS: assert property (
      @(posedge pclk) disable iff (!presetn)
      (out_freq > startf_q) |=> run_q)
      else $error("run flag missed frequency above start");
   AST_RUN_STOP: assert property (
      @(posedge pclk) disable iff (!presetn)
      (out_freq <= startf_q) |=> !run_q)
      else $error("run flag held while stopped");
   AST_OUT1_ROUTE: assert property (
      @(posedge pclk) disable iff (!presetn)
      (sel1_q == status_out_pkg::FN_RUN && $stable(sel1_q))
      |=> relays.out1_no == run_q)
      else $error("relay 1 not following run function");
   AST_SETPOINT_ON: assert property (
      @(posedge pclk) disable iff (!presetn)
      (out_freq == setf_q) |=> arrival_at_setpoint_flag_q)
      else $error("setpoint flag off at set frequency");
   AST_OVER_DROP: assert property (
      @(posedge pclk) disable iff (!presetn)
      (out_freq < prev_q && {1'b0, out_freq} + {1'b0, band_off}
      < {1'b0, dec_q}) |=> !arrival_over_threshold_flag_q)
      else $error("over-threshold flag stayed on below decel point");
   AST_OVER_RISE: assert property (
      @(posedge pclk) disable iff (!presetn)
      (out_freq > prev_q && {1'b0, out_freq} + {1'b0, band_on}
      >= {1'b0, acc_q}) |=> arrival_over_threshold_flag_q)
      else $error("over-threshold flag missed accel threshold");
   AST_DIR_HOLD: assert property (
      @(posedge pclk) disable iff (!presetn)
      (out_freq == prev_q) |=> $stable(dir_q))
      else $error("direction changed at constant frequency");
   AST_AT_THR_ON: assert property (
      @(posedge pclk) disable iff (!presetn)
      (out_freq < prev_q && near_thr(out_freq, dec_q, band_on))
      |=> arrival_at_threshold_pulse_q)
      else $error("threshold pulse missed decel threshold");
   AST_AT_THR_LEAVE: assert property (
      @(posedge pclk) disable iff (!presetn)
      (dir_d == DIR_ACCEL && !near_thr(out_freq, acc_q, band_off)
      && !near_thr(out_freq, dec_q, band_off))
      |=> !arrival_at_threshold_pulse_q)
      else $error("threshold pulse stayed on past threshold");
   AST_ALARM_DEFAULT: assert property (
      @(posedge pclk) disable iff (!presetn)
      (sela_q == status_out_pkg::FN_ALARM && $stable(sela_q) && alarm_in)
      |=> relays.alarm_no)
      else $error("alarm relay not carrying alarm");
endmodule

// ### logic/status_out_pkg.sv
/*
 * Shared constants and types of the drive status-output selector: APB
 * register map, option codes, reset values and the relay pin group.
 * Assumes frequencies arrive as unsigned words in one common unit.
 */
package status_out_pkg;

   // Frequency word width
   localparam int FREQ_W = 16;

   // Register byte offsets
   localparam logic [11:0] OFS_SEL_OUT1 = 12'h000;
   localparam logic [11:0] OFS_SEL_OUT2 = 12'h004;
   localparam logic [11:0] OFS_SEL_ALARM = 12'h008;
   localparam logic [11:0] OFS_SET_FREQ = 12'h00C;
   localparam logic [11:0] OFS_ACC_THR = 12'h010;
   localparam logic [11:0] OFS_DEC_THR = 12'h014;
   localparam logic [11:0] OFS_START_FREQ = 12'h018;
   localparam logic [11:0] OFS_MAX_FREQ = 12'h01C;
   localparam logic [11:0] OFS_STATUS = 12'h020;

   // Output function option codes
   localparam logic [7:0] FN_RUN = 8'h00;
   localparam logic [7:0] FN_SETPOINT = 8'h01;
   localparam logic [7:0] FN_OVER_THR = 8'h02;
   localparam logic [7:0] FN_AT_THR = 8'h06;
   localparam logic [7:0] FN_ALARM = 8'h05;

   // Values after reset
   localparam logic [7:0] RST_SEL_OUT1 = 8'h00;
   localparam logic [7:0] RST_SEL_OUT2 = 8'h01;
   localparam logic [7:0] RST_SEL_ALARM = 8'h05;
   localparam logic [15:0] RST_SET_FREQ = 16'h0000;
   localparam logic [15:0] RST_ACC_THR = 16'h0000;
   localparam logic [15:0] RST_DEC_THR = 16'h0000;
   localparam logic [15:0] RST_START_FREQ = 16'h0032;
   localparam logic [15:0] RST_MAX_FREQ = 16'h1770;

   // Hysteresis as percent of maximum frequency
   localparam int ON_PCT = 1;
   localparam int OFF_PCT = 2;

   // Status register bit positions
   localparam int ST_RUN = 0;
   localparam int ST_SETPOINT = 1;
   localparam int ST_OVER = 2;
   localparam int ST_AT = 3;
   localparam int ST_ACCEL = 4;
   localparam int ST_DECEL = 5;

   // Relay contact group
   typedef struct packed {
      logic out1_no;
      logic out2_no;
      logic alarm_no;
      logic alarm_nc;
   } relay_t;

endpackage

// ### verification/relay_inputs.sv
/*
 * Far-side model: controller digital inputs wired to the relay contacts.
 * Assumes each input is pulled up and a closed contact shorts it low.
 */
module relay_inputs (
   // Relay contacts from the drive
   input wire status_out_pkg::relay_t relays,
   // Sensed controller inputs, low while the contact is closed
   output logic [3:0] din_n
);
   timeunit 1ns;
   timeprecision 1ps;

   // A closed contact pulls its pulled-up input to ground
   assign din_n = ~relays;
endmodule

// ### verification/tb_drive_status_output_selector.sv
/*
 * Self-checking bench of the status-output selector: APB master, frequency
 * stimulus and a queue of expected results checked by a monitor process.
 * Assumes the zero-wait APB slave and one-cycle relay latency of the block.
 */
module tb_drive_status_output_selector;
   timeunit 1ns;
   timeprecision 1ps;

   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic alarm_in, probe;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [15:0] out_freq, sf;
   logic [3:0] din_n;
   status_out_pkg::relay_t relays;
   logic [32:0] exp_q[$];
   int failures = 0;
   int num_checks = 0;
   integer seed = 32'h9CE11647;

   // Clock at 100 MHz
   always #5 pclk = ~pclk;

   status_out_sel i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .out_freq(out_freq), .alarm_in(alarm_in), .relays(relays));

   relay_inputs i_load (.relays(relays), .din_n(din_n));

   // Compare one value and count the result
   task automatic check(input string what, input logic [32:0] seen,
                        input logic [32:0] want);
      num_checks++;
      if (seen !== want) begin
         failures++;
         $display("BAD %s exp %h seen %h", what, want, seen);
      end
   endtask

   // Print the counts and the verdict, then end the run
   task automatic stop_test;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Monitor: each finished transfer or probe takes the oldest note
   always @(posedge pclk) begin
      if ((psel && penable && pready) || probe) begin
         if (exp_q.size() == 0)
            check("queue", 33'h1, 33'h0);
         else if (probe)
            check("relays", {29'h0, ~din_n}, exp_q.pop_front());
         else
            check("apb", {pslverr, pwrite ? 32'h0 : prdata},
                  exp_q.pop_front());
      end
   end

   // One APB transfer, held until pready is seen high
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d, input logic [32:0] want);
      int n;
      exp_q.push_back(want);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge pclk);
         if (pready === 1'b1)
            break;
      end
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 20) begin
         failures++;
         stop_test();
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 33'h0);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] v);
      apb(1'b0, a, 32'h0, {1'b0, v});
   endtask

   // Apply a frequency, let the relays settle, then probe them
   task automatic go(input logic [15:0] f, input logic [3:0] want);
      @(posedge pclk);
      out_freq <= f;
      repeat (2) @(posedge pclk);
      exp_q.push_back({29'h0, want});
      probe <= 1'b1;
      @(posedge pclk);
      probe <= 1'b0;
   endtask

   // Hang guard
   initial begin
      repeat (20000) @(posedge pclk);
      failures++;
      stop_test();
   end

   // Main sequence
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      out_freq = 16'h0000;
      alarm_in = 1'b0;
      probe = 1'b0;
      sf = 16'h03E8 + 16'($random(seed) & 32'h3FF);
      repeat (8) @(posedge pclk);
      check("reset relays", {29'h0, relays}, 33'h1);
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rd(status_out_pkg::OFS_SEL_OUT1, 32'h0);
      rd(status_out_pkg::OFS_SEL_OUT2, 32'h1);
      rd(status_out_pkg::OFS_SEL_ALARM, 32'h5);
      rd(status_out_pkg::OFS_START_FREQ,
         {16'h0, status_out_pkg::RST_START_FREQ});
      rd(status_out_pkg::OFS_MAX_FREQ,
         {16'h0, status_out_pkg::RST_MAX_FREQ});
      apb(1'b0, 12'h024, 32'h0, {1'b1, 32'h0});
      apb(1'b1, status_out_pkg::OFS_STATUS, 32'hF, {1'b1, 32'h0});
      wr(status_out_pkg::OFS_SET_FREQ, {16'h0, sf});
      go(16'h0032, 4'h1);
      go(16'h0033, 4'h9);
      alarm_in <= 1'b1;
      go(16'h0033, 4'hA);
      alarm_in <= 1'b0;
      go(sf, 4'hD);
      go(sf + 16'h01F4, 4'h9);
      // Three arrival functions on the three relays at once
      wr(status_out_pkg::OFS_ACC_THR, 32'hBB8);
      wr(status_out_pkg::OFS_DEC_THR, 32'h7D0);
      rd(status_out_pkg::OFS_ACC_THR, 32'hBB8);
      wr(status_out_pkg::OFS_SET_FREQ, 32'hBB8);
      wr(status_out_pkg::OFS_SEL_OUT1, 32'h2);
      wr(status_out_pkg::OFS_SEL_OUT2, 32'h6);
      wr(status_out_pkg::OFS_SEL_ALARM, 32'h1);
      go(16'h0000, 4'h1);
      go(16'h0B7B, 4'h1);
      go(16'h0B7C, 4'hE);
      go(16'h0DAC, 4'h9);
      go(16'h07D0, 4'hD);
      rd(status_out_pkg::OFS_STATUS, 32'h2D);
      wr(status_out_pkg::OFS_SEL_OUT2, 32'h0);
      go(16'h0758, 4'hD);
      go(16'h0757, 4'h5);
      wr(status_out_pkg::OFS_SEL_OUT2, 32'h7F);
      go(16'h0757, 4'h1);
      stop_test();
   end
endmodule
